// file: core/pmsc_checker.sv
/*
 Receive-side checker and unpacker for secure paging messages.
 Assumes decoded, error-corrected information words arrive one per cycle
 with a message start strobe and descriptor ahead of them.
*/
// Behaviour
// - Numbers count up from zero to seq_wrap, at most 63; one expected counter per address slot.
// - Wrap point comes from a configuration input, not a fixed constant.
// - Out-of-order number raises missed pulse with skipped range.
// - Messages with retrieval flag clear skip sequence checking entirely.
// - Characters start at the second word of each fragment, seven bits each.
// - Reassembly waits up to four minutes between fragments before abandoning.
// - Temporary group addresses get no sequence checking.
// - Accepting type 011 implies accepting type 010 with short type 00.
// - Type 101 implies 011 and 010; any-phase adds 001 with instruction 000.
// - All four rate and modulation pairs are accepted.
// - Single-phase or any-phase addressing is a configuration input.
// - Unhandled control characters take no display space but are passed on.
// - Each fragment checked against ones complement of 10-bit group sum.
// - Continuation flag set means more fragments follow; clear ends message.
// - Fragment index starts 11, then counts modulo three skipping 11.
`timescale 1ns/10ps
`include "pmsc_params.svh"

module pmsc_checker #(
   parameter int SLOTS     = 8,
   parameter int TICK_CYC  = `PMSC_TICK_CYC,
   parameter int GAP_TICKS = `PMSC_GAP_TICKS
) (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        arst_n,
   input  wire logic                        clear_i,
   // Configuration
   input  wire logic [5:0]                  seq_wrap,
   input  wire logic                        any_phase_en,
   input  wire logic                        support_numeric,
   input  wire logic                        support_alpha,
   input  wire pmsc_pkg::pmsc_rate_e        rate_mode,
   output      logic                        rate_ok,
   // Message start
   input  wire logic                        msg_start,
   input  wire pmsc_pkg::pmsc_hdr_s         msg_hdr,
   input  wire logic [$clog2(SLOTS)-1:0]    msg_slot,
   output      logic                        msg_accept,
   output      logic                        msg_reject,
   // Message words
   input  wire logic                        word_valid,
   input  wire logic [20:0]                 word_data,
   input  wire logic                        word_last,
   // Characters
   output      pmsc_pkg::pmsc_chars_s       chars,
   // Events
   output      logic                        missed,
   output      logic [5:0]                  missed_from,
   output      logic [5:0]                  missed_to,
   output      logic                        frag_ok,
   output      logic                        frag_bad,
   output      logic                        frag_seq_err,
   output      logic                        msg_more,
   output      logic [SLOTS-1:0]            frag_timeout
);

   localparam int SW = $clog2(SLOTS);
   localparam int TW = $clog2(TICK_CYC + 1);
   localparam int GW = $clog2(GAP_TICKS + 2);

   // ------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------
   if (SLOTS < 2 || (SLOTS & (SLOTS - 1)) != 0 || TICK_CYC < 1 || GAP_TICKS < 1) begin : g_bad
      $error("pmsc_checker: unsupported parameter values");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   pmsc_pkg::pmsc_state_e state_r, state_nxt;
   pmsc_pkg::pmsc_hdr_s   hdr_r;
   logic [SW-1:0]         slot_r;
   logic [9:0]            sum_r, sum_nxt;
   logic [9:0]            chk_r;
   logic [TW-1:0]         tick_cnt_r;
   logic                  tick;
   logic [5:0]            exp_r  [SLOTS];
   logic                  seen_r [SLOTS];
   logic                  open_r [SLOTS];
   logic [1:0]            next_r [SLOTS];
   logic [GW-1:0]         gap_r  [SLOTS];
   logic [SLOTS-1:0]      open_vec;

   // ------------------------------------------------------------
   // Vector acceptance
   // ------------------------------------------------------------
   wire pmsc_pkg::pmsc_vec_e vt = msg_hdr.vector_type_code;
   wire num_cap = support_numeric | support_alpha;
   wire acc_alpha = support_alpha & (vt == pmsc_pkg::VEC_ALPHA || vt == pmsc_pkg::VEC_SECURE);
   wire acc_num   = num_cap & (vt == pmsc_pkg::VEC_NUM);
   wire acc_short = num_cap & (vt == pmsc_pkg::VEC_SHORT) & (msg_hdr.short_msg_type == 2'h0);
   wire acc_instr = support_alpha & any_phase_en & (vt == pmsc_pkg::VEC_INSTR)
                    & (msg_hdr.instruction_type == 3'h0);
   wire accept    = acc_alpha | acc_num | acc_short | acc_instr;
   wire secure    = accept & (vt == pmsc_pkg::VEC_SECURE);
   assign rate_ok = (rate_mode == pmsc_pkg::RATE_1600_2L) || (rate_mode == pmsc_pkg::RATE_3200_2L)
                    || (rate_mode == pmsc_pkg::RATE_3200_4L) || (rate_mode == pmsc_pkg::RATE_6400_4L);

   // ------------------------------------------------------------
   // Header word decode
   // ------------------------------------------------------------
   wire       in_hdr   = (state_r == pmsc_pkg::ST_HDR);
   wire       in_body  = (state_r == pmsc_pkg::ST_BODY);
   wire       hdr_take = word_valid & in_hdr;
   wire       body_take = word_valid & in_body;
   wire [1:0] f_in     = word_data[`PMSC_FRAG_MSB:`PMSC_FRAG_LSB];
   wire       c_in     = word_data[`PMSC_CONT_BIT];
   wire [5:0] n_in     = word_data[`PMSC_NUM_MSB:`PMSC_NUM_LSB];
   wire       is_start = (f_in == `PMSC_FRAG_START);
   // numbered messages on non-temporary addresses only
   wire       seq_on   = is_start & hdr_r.retrieval & ~hdr_r.temp;
   wire [5:0] exp_cur  = exp_r[slot_r];
   wire       seq_gap  = seq_on & seen_r[slot_r] & (n_in != exp_cur);
   wire [5:0] wrap_lim = (seq_wrap > `PMSC_SEQ_MAX) ? `PMSC_SEQ_MAX : seq_wrap;
   wire [5:0] exp_new  = (n_in >= wrap_lim) ? `PMSC_EXP_RESET : n_in + 6'h01;
   wire [5:0] gap_end  = (n_in == 6'h00) ? wrap_lim : n_in - 6'h01;
   wire       cont_ok  = ~is_start & open_r[slot_r] & (f_in == next_r[slot_r]);
   wire [1:0] f_step   = (f_in == `PMSC_FRAG_LAST) ? `PMSC_FRAG_FIRST : f_in + 2'h1;
   wire       open_new = (is_start | cont_ok) & c_in;
   wire [1:0] next_new = is_start ? `PMSC_FRAG_FIRST : f_step;

   // ------------------------------------------------------------
   // Fragment check sum
   // ------------------------------------------------------------
   // pad bits summed as received, no meaning given
   wire [20:0] sum_word = in_hdr ? {word_data[20:10], 10'h000} : word_data;
   wire [9:0]  grp_sum  = 10'(sum_word[7:0]) + 10'(sum_word[15:8]) + 10'(sum_word[20:16]);
   assign sum_nxt = in_hdr ? grp_sum : sum_r + grp_sum;
   wire [9:0]  chk_use  = in_hdr ? word_data[`PMSC_CHK_MSB:`PMSC_CHK_LSB] : chk_r;
   wire        sum_good = ((~sum_nxt) == chk_use);
   wire        frag_end = (hdr_take | body_take) & word_last;

   // ------------------------------------------------------------
   // Character unpack
   // ------------------------------------------------------------
   pmsc_pkg::pmsc_chars_s chars_nxt;
   for (genvar k = 0; k < 3; k++) begin : g_char
      wire [6:0] code_k = word_data[7*k +: 7];
      assign chars_nxt.code[k]  = code_k;
      assign chars_nxt.valid[k] = body_take & (code_k != `PMSC_FILL_CHAR);
      assign chars_nxt.ctrl[k]  = (code_k < `PMSC_CTRL_TOP) | (code_k == `PMSC_DEL_CHAR);
   end

   // ------------------------------------------------------------
   // Word stage
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         pmsc_pkg::ST_IDLE: begin
            if (msg_start) state_nxt = secure ? pmsc_pkg::ST_HDR : pmsc_pkg::ST_SKIP;
         end
         pmsc_pkg::ST_HDR: begin
            if (word_valid) state_nxt = word_last ? pmsc_pkg::ST_IDLE : pmsc_pkg::ST_BODY;
         end
         pmsc_pkg::ST_BODY, pmsc_pkg::ST_SKIP: begin
            if (word_valid && word_last) state_nxt = pmsc_pkg::ST_IDLE;
         end
         default: state_nxt = pmsc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= pmsc_pkg::ST_IDLE;
         hdr_r   <= '0;
         slot_r  <= '0;
         sum_r   <= '0;
         chk_r   <= '0;
      end else begin
         state_r <= clear_i ? pmsc_pkg::ST_IDLE : state_nxt;
         if (msg_start && state_r == pmsc_pkg::ST_IDLE) begin
            hdr_r  <= msg_hdr;
            slot_r <= msg_slot;
         end
         if (hdr_take || body_take) sum_r <= sum_nxt;
         if (hdr_take) chk_r <= word_data[`PMSC_CHK_MSB:`PMSC_CHK_LSB];
      end
   end

   // ------------------------------------------------------------
   // Output events
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         chars        <= '0;
         msg_accept   <= 1'b0;
         msg_reject   <= 1'b0;
         missed       <= 1'b0;
         missed_from  <= '0;
         missed_to    <= '0;
         frag_ok      <= 1'b0;
         frag_bad     <= 1'b0;
         frag_seq_err <= 1'b0;
         msg_more     <= 1'b0;
      end else begin
         chars        <= clear_i ? '0 : chars_nxt;
         msg_accept   <= ~clear_i & msg_start & (state_r == pmsc_pkg::ST_IDLE) & accept;
         msg_reject   <= ~clear_i & msg_start & (state_r == pmsc_pkg::ST_IDLE) & ~accept;
         missed       <= ~clear_i & hdr_take & seq_gap;
         if (hdr_take && seq_gap) begin
            missed_from <= exp_cur;
            missed_to   <= gap_end;
         end
         frag_ok      <= ~clear_i & frag_end & sum_good;
         frag_bad     <= ~clear_i & frag_end & ~sum_good;
         frag_seq_err <= ~clear_i & hdr_take & ~is_start & ~cont_ok;
         msg_more     <= ~clear_i & hdr_take & open_new;
      end
   end

   // ------------------------------------------------------------
   // Timeout tick
   // ------------------------------------------------------------
   assign tick = (tick_cnt_r == TW'(TICK_CYC - 1));
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) tick_cnt_r <= '0;
      else tick_cnt_r <= (tick || clear_i) ? '0 : tick_cnt_r + TW'(1);
   end

   // ------------------------------------------------------------
   // Per-slot sequence and reassembly state
   // ------------------------------------------------------------
   for (genvar i = 0; i < SLOTS; i++) begin : g_slot
      wire upd    = hdr_take & (slot_r == SW'(i));
      wire expire = open_r[i] & tick & (gap_r[i] == GW'(GAP_TICKS));
      assign open_vec[i] = open_r[i];
      always_ff @(posedge ref_clk or negedge arst_n) begin
         if (!arst_n) begin
            exp_r[i]        <= `PMSC_EXP_RESET;
            seen_r[i]       <= 1'b0;
            open_r[i]       <= 1'b0;
            next_r[i]       <= `PMSC_FRAG_FIRST;
            gap_r[i]        <= '0;
            frag_timeout[i] <= 1'b0;
         end else if (clear_i) begin
            exp_r[i]        <= `PMSC_EXP_RESET;
            seen_r[i]       <= 1'b0;
            open_r[i]       <= 1'b0;
            next_r[i]       <= `PMSC_FRAG_FIRST;
            gap_r[i]        <= '0;
            frag_timeout[i] <= 1'b0;
         end else begin
            frag_timeout[i] <= expire & ~upd;
            if (upd) begin
               open_r[i] <= open_new;
               next_r[i] <= next_new;
               gap_r[i]  <= '0;
               if (seq_on) begin
                  exp_r[i]  <= exp_new;
                  seen_r[i] <= 1'b1;
               end
            end else if (expire) begin
               open_r[i] <= 1'b0;
            end else if (open_r[i] && tick) begin
               gap_r[i]  <= gap_r[i] + GW'(1);
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   chk_unnumbered_quiet: assert property (missed |-> $past(hdr_r.retrieval) && !$past(hdr_r.temp))
      else $error("missed raised for unnumbered or temporary message");
   chk_gap_reported: assert property (hdr_take && seq_gap && !clear_i |=> missed ##1 !missed)
      else $error("sequence gap not reported as one pulse");
   chk_gap_range: assert property (missed |-> missed_to == $past(gap_end) && missed_from == $past(exp_cur))
      else $error("missed range wrong");
   chk_wrap_point: assert property (hdr_take && seq_on && !clear_i && n_in >= wrap_lim |=> exp_cur == 6'h00)
      else $error("sequence did not wrap at configured ceiling");
   chk_fill_dropped: assert property (chars.valid[0] |-> chars.code[0] != `PMSC_FILL_CHAR)
      else $error("fill character passed as content");
   chk_char_source: assert property ((|chars.valid) |-> $past(in_body) && $past(word_valid))
      else $error("characters from a non-body word");
   chk_ctrl_flag: assert property (chars.valid[1] |->
      chars.ctrl[1] == (chars.code[1] < 7'h20 || chars.code[1] == 7'h7F))
      else $error("control flag wrong");
   chk_sum_verdict: assert property (frag_end && !clear_i |=> frag_ok != frag_bad)
      else $error("fragment end without one verdict");
   chk_orphan_frag: assert property (hdr_take && !is_start && !open_r[slot_r] && !clear_i |=> frag_seq_err)
      else $error("continuation without open message not flagged");
   chk_clear_all: assert property (clear_i |=> !missed && open_vec == '0 && frag_timeout == '0)
      else $error("clear left state behind");

   cov_missed:  cover property (missed);
   cov_frag_ok: cover property (msg_more ##[1:40] frag_ok);
   cov_timeout: cover property (|frag_timeout);
   cov_chars:   cover property (chars.valid == 3'h7);

endmodule

// file: common/pmsc_params.svh
/*
 Constants of the paging message sequence checker: message header field
 positions, fill code, fragment index values and timing figures.
 Assumes a 21-bit information word, bit 0 first on air.
*/
`ifndef PMSC_PARAMS_SVH
`define PMSC_PARAMS_SVH

// ------------------------------------------------------------
// Header word fields
// ------------------------------------------------------------
`define PMSC_CHK_LSB      0
`define PMSC_CHK_MSB      9
`define PMSC_CONT_BIT     10
`define PMSC_FRAG_LSB     11
`define PMSC_FRAG_MSB     12
`define PMSC_NUM_LSB      13
`define PMSC_NUM_MSB      18

// ------------------------------------------------------------
// Codes and reset values
// ------------------------------------------------------------
`define PMSC_FRAG_START   2'h3
`define PMSC_FRAG_FIRST   2'h0
`define PMSC_FRAG_LAST    2'h2
`define PMSC_FILL_CHAR    7'h03
`define PMSC_DEL_CHAR     7'h7F
`define PMSC_CTRL_TOP     7'h20
`define PMSC_SEQ_MAX      6'h3F
`define PMSC_EXP_RESET    6'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PMSC_CLK_MHZ      200
`define PMSC_TICK_US      1000
`define PMSC_TICK_CYC     (`PMSC_CLK_MHZ * `PMSC_TICK_US)
`define PMSC_GAP_MIN      4
`define PMSC_GAP_TICKS    (`PMSC_GAP_MIN * 60 * 1000)

`endif

// file: common/pmsc_pkg.sv
/*
 Types of the paging message sequence checker.
 Assumes nothing beyond the constants header.
*/
package pmsc_pkg;

   // Vector types carried by the address/vector stage
   typedef enum logic [2:0] {
      VEC_SECURE = 3'h0,
      VEC_INSTR  = 3'h1,
      VEC_SHORT  = 3'h2,
      VEC_NUM    = 3'h3,
      VEC_NUMS   = 3'h4,
      VEC_ALPHA  = 3'h5,
      VEC_HEX    = 3'h6,
      VEC_NUMN   = 3'h7
   } pmsc_vec_e;

   // Data rate and modulation pairs
   typedef enum logic [1:0] {
      RATE_1600_2L = 2'h0,
      RATE_3200_2L = 2'h1,
      RATE_3200_4L = 2'h2,
      RATE_6400_4L = 2'h3
   } pmsc_rate_e;

   // Word stage state
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_HDR  = 4'h2,
      ST_BODY = 4'h4,
      ST_SKIP = 4'h8
   } pmsc_state_e;

   // Message descriptor given at message start
   typedef struct packed {
      logic      temp;
      logic      retrieval;
      pmsc_vec_e vector_type_code;
      logic [1:0] short_msg_type;
      logic [2:0] instruction_type;
   } pmsc_hdr_s;

   // Characters unpacked from one body word
   typedef struct packed {
      logic [2:0]      valid;
      logic [2:0]      ctrl;
      logic [2:0][6:0] code;
   } pmsc_chars_s;

endpackage

// file: testbench/pmsc_encoder_model.sv
/*
 Encoder model: drives message starts, header words and body words.
 Assumes calls are made by the bench; all changes land on falling edges.
*/
`timescale 1ns/10ps
module pmsc_encoder_model (
   // Clock
   input  wire logic          ref_clk,
   // Message start
   output logic               msg_start,
   output pmsc_pkg::pmsc_hdr_s msg_hdr,
   output logic [2:0]         msg_slot,
   // Message words
   output logic               word_valid,
   output logic [20:0]        word_data,
   output logic               word_last
);
   logic [20:0] w_q[$];

   initial begin
      msg_start  = 1'b0;
      msg_hdr    = '0;
      msg_slot   = 3'h0;
      word_valid = 1'b0;
      word_data  = 21'h0;
      word_last  = 1'b0;
   end

   function automatic logic [6:0] chr(input int k, input int n);
      if (k >= n) return 7'h03;
      if (k == 1) return 7'h0D;
      return 7'h41 + 7'(k);
   endfunction

   task automatic idle();
      word_valid <= 1'b0;
      word_last  <= 1'b0;
      word_data  <= ~word_data;
      @(negedge ref_clk);
   endtask

   task automatic send_msg(input pmsc_pkg::pmsc_hdr_s h, input logic [2:0] s, input logic [5:0] n,
                           input logic [1:0] f, input logic c, input int nch, input logic bad, input int gap);
      logic [9:0] sum;
      w_q.delete();
      w_q.push_back({2'h0, n, f, c, 10'h000});
      for (int k = 0; k < nch; k += 3) w_q.push_back({chr(k + 2, nch), chr(k + 1, nch), chr(k, nch)});
      sum = 10'h000;
      foreach (w_q[i]) sum += w_q[i][7:0] + w_q[i][15:8] + w_q[i][20:16];
      w_q[0][9:0] = ~sum ^ {9'h000, bad};
      @(negedge ref_clk);
      msg_start <= 1'b1;
      msg_hdr   <= h;
      msg_slot  <= s;
      @(negedge ref_clk);
      msg_start <= 1'b0;
      msg_slot  <= ~s;
      foreach (w_q[i]) begin
         word_valid <= 1'b1;
         word_data  <= w_q[i];
         word_last  <= (i == w_q.size() - 1);
         @(negedge ref_clk);
         if (i < w_q.size() - 1) repeat (gap) idle();
      end
      idle();
   endtask
endmodule

// file: testbench/pmsc_checker_test.sv
/*
 Self-checking bench of the sequence checker.
 Assumes the encoder model owns the message side; the bench owns configuration.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
   $display("mismatch at %0t: got %0h exp %0h", $time, a, b); end end
module pmsc_checker_test;
   localparam int TICK = 4;
   localparam int GAP  = 5;
   localparam logic [31:0] E_OK   = 32'h0100_0110;
   localparam logic [31:0] E_MISS = 32'h1100_0110;
   localparam logic [31:0] E_MORE = 32'h0100_1110;
   localparam pmsc_pkg::pmsc_vec_e SEC = pmsc_pkg::VEC_SECURE;
   logic                  ref_clk, arst_n, clear_i, any_phase_en, support_numeric, support_alpha;
   logic [5:0]            seq_wrap, missed_from, missed_to;
   pmsc_pkg::pmsc_rate_e  rate_mode;
   logic                  rate_ok, msg_start, msg_accept, msg_reject, word_valid, word_last;
   pmsc_pkg::pmsc_hdr_s   msg_hdr;
   logic [2:0]            msg_slot;
   logic [20:0]           word_data;
   pmsc_pkg::pmsc_chars_s chars;
   logic                  missed, frag_ok, frag_bad, frag_seq_err, msg_more;
   logic [7:0]            frag_timeout;
   logic [7:0][3:0]       cnt;
   logic [31:0]           msk;
   logic [6:0]            got_q[$];
   int                    err_total = 0;
   int                    n_checks = 0;
   int                    rej_cnt = 0;
   int                    k;
   wire  [7:0]            ev = {missed, frag_ok, frag_bad, frag_seq_err, msg_more, msg_accept,
                                |(chars.ctrl & chars.valid), |frag_timeout};

   pmsc_checker #(.SLOTS(8), .TICK_CYC(TICK), .GAP_TICKS(GAP)) pmsc_checker_inst (
      .ref_clk, .arst_n, .clear_i, .seq_wrap, .any_phase_en, .support_numeric, .support_alpha,
      .rate_mode, .rate_ok, .msg_start, .msg_hdr, .msg_slot, .msg_accept, .msg_reject,
      .word_valid, .word_data, .word_last, .chars, .missed, .missed_from, .missed_to,
      .frag_ok, .frag_bad, .frag_seq_err, .msg_more, .frag_timeout);

   pmsc_encoder_model pmsc_encoder_model_inst (
      .ref_clk, .msg_start, .msg_hdr, .msg_slot, .word_valid, .word_data, .word_last);

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Event counters and character capture
   always @(negedge ref_clk) begin
      for (int j = 0; j < 8; j++) cnt[j] = cnt[j] + 4'(ev[j] === 1'b1);
      for (int j = 0; j < 3; j++) if (chars.valid[j] === 1'b1) got_q.push_back(chars.code[j]);
      rej_cnt = rej_cnt + int'(msg_reject === 1'b1);
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic msg(input logic t, input logic r, input pmsc_pkg::pmsc_vec_e v, input logic [2:0] s,
                      input logic [5:0] n, input logic [1:0] f, input logic c, input int nch,
                      input logic bad, input logic [31:0] exp);
      @(posedge ref_clk);
      cnt = '0;
      rej_cnt = 0;
      got_q.delete();
      pmsc_encoder_model_inst.send_msg('{t, r, v, 2'h0, 3'h0}, s, n, f, c, nch, bad, int'(n[0]));
      repeat (2) @(negedge ref_clk);
      `CHK(cnt & msk, exp)
      if (msk == '1) begin
         `CHK(got_q.size(), nch)
         foreach (got_q[i]) `CHK(got_q[i], pmsc_encoder_model_inst.chr(i, nch))
      end
   endtask

   initial begin
      {arst_n, clear_i, any_phase_en, support_numeric, support_alpha} = 5'b00001;
      seq_wrap  = 6'h3F;
      rate_mode = pmsc_pkg::RATE_1600_2L;
      msk = '1;
      cnt = '0;
      repeat (20) @(negedge ref_clk);
      arst_n = 1'b1;
      for (k = 0; k < 4; k++) begin
         rate_mode = pmsc_pkg::pmsc_rate_e'(k);
         @(posedge ref_clk);
         `CHK(rate_ok, 1'b1)
         @(negedge ref_clk);
      end
      msg(0, 1, SEC, 0, 6'h00, 3, 0, 4, 0, E_OK);
      msg(0, 1, SEC, 0, 6'h01, 3, 0, 4, 0, E_OK);
      msg(0, 1, SEC, 0, 6'h04, 3, 0, 4, 0, E_MISS);
      `CHK({missed_from, missed_to}, 12'h083)
      msg(0, 0, SEC, 0, 6'h09, 3, 0, 4, 0, E_OK);
      msg(1, 1, SEC, 0, 6'h14, 3, 0, 4, 0, E_OK);
      seq_wrap = 6'h05;
      msg(0, 1, SEC, 0, 6'h05, 3, 0, 4, 0, E_OK);
      msg(0, 1, SEC, 0, 6'h00, 3, 0, 4, 0, E_OK);
      msg(0, 1, SEC, 0, 6'h02, 3, 0, 4, 0, E_MISS);
      `CHK({missed_from, missed_to}, 12'h041)
      seq_wrap = 6'h3F;
      msg(0, 1, SEC, 1, 6'h3F, 3, 0, 4, 0, E_OK);
      msg(0, 1, SEC, 1, 6'h00, 3, 0, 4, 0, E_OK);
      msg(0, 1, SEC, 1, 6'h01, 3, 0, 2, 1, 32'h0010_0110);
      msg(0, 1, SEC, 1, 6'h00, 3, 0, 4, 0, E_MISS);
      `CHK({missed_from, missed_to}, 12'h0BF)
      msg(0, 1, SEC, 2, 6'h07, 3, 1, 3, 0, E_MORE);
      for (k = 0; k < 3; k++) msg(0, 1, SEC, 2, 6'h07, k[1:0], 1, 3, 0, E_MORE);
      msg(0, 1, SEC, 2, 6'h07, 0, 0, 3, 0, E_OK);
      msg(0, 1, SEC, 3, 6'h07, 3, 1, 4, 0, E_MORE);
      msg(0, 1, SEC, 4, 6'h08, 3, 1, 4, 0, E_MORE);
      k = 0;
      while (frag_timeout[4] !== 1'b1 && k < 100) begin
         @(negedge ref_clk);
         k++;
      end
      `CHK(k >= GAP * TICK - 8 && k <= (GAP + 2) * TICK, 1'b1)
      @(negedge ref_clk);
      `CHK(cnt[0], 4'h2)
      if (k >= 100) stop_test();
      msg(0, 1, SEC, 5, 6'h09, 3, 1, 4, 0, E_MORE);
      repeat (2 * TICK) @(negedge ref_clk);
      msg(0, 1, SEC, 5, 6'h09, 0, 0, 4, 0, E_OK);
      msg(0, 1, SEC, 6, 6'h0A, 3, 1, 4, 0, E_MORE);
      clear_i = 1'b1;
      @(negedge ref_clk);
      clear_i = 1'b0;
      msg(0, 1, SEC, 0, 6'h0A, 3, 0, 4, 0, E_OK);
      msk = 32'h000F_0000;
      msg(0, 1, SEC, 3, 6'h07, 1, 1, 4, 0, 32'h0001_0000);
      msg(0, 1, SEC, 4, 6'h08, 0, 0, 4, 0, 32'h0001_0000);
      msg(0, 1, SEC, 6, 6'h0A, 0, 0, 4, 0, 32'h0001_0000);
      msk = 32'h0000_0F00;
      {support_numeric, support_alpha} = 2'b10;
      msg(0, 0, pmsc_pkg::VEC_NUM, 0, 6'h00, 3, 0, 0, 0, 32'h100);
      msg(0, 0, pmsc_pkg::VEC_SHORT, 0, 6'h00, 3, 0, 0, 0, 32'h100);
      {support_numeric, support_alpha, any_phase_en} = 3'b011;
      for (k = 1; k < 6; k++) if (k != 4) msg(0, 0, pmsc_pkg::pmsc_vec_e'(k), 0, 0, 3, 0, 0, 0, 32'h100);
      any_phase_en = 1'b0;
      msg(0, 0, pmsc_pkg::VEC_INSTR, 0, 0, 3, 0, 0, 0, 32'h000);
      `CHK(rej_cnt, 1)
      stop_test();
   end
endmodule
